// *** include/itcr_defines.svh ***
// Offsets, field positions and reset values of the interrupt and transceive register group.
// Assumes inclusion by bare name from files that also see the itcr_pkg package.
`ifndef ITCR_DEFINES_SVH
`define ITCR_DEFINES_SVH

`define ITCR_OFS_IRQ_EN 8'h01
`define ITCR_OFS_IRQ_STATUS 8'h02
`define ITCR_OFS_IRQ_CLEAR 8'h03
`define ITCR_OFS_TRX_CTL 8'h04
`define ITCR_OFS_PIN_CFG 8'h05

`define ITCR_FLAG_W 20
`define ITCR_CLR_W 21
`define ITCR_CLR_HI_MSB 20
`define ITCR_CLR_HI_LSB 15
`define ITCR_CLR_LO_MSB 13
`define ITCR_CTL_W 10
`define ITCR_PIN_W 8
`define ITCR_GPO_N 7
`define ITCR_PIN_SLEW 7

`define ITCR_RST_IRQ_EN 20'h0_0000
`define ITCR_RST_TRX_CTL 10'h000
`define ITCR_RST_PIN_CFG 8'h00
`define ITCR_RST_DATA 32'h0000_0000

`endif

// *** include/itcr_pkg.sv ***
// Types of the interrupt and transceive register group.
// Assumes nothing beyond a SystemVerilog compiler.
package itcr_pkg;

    // Transceive states, in the order of the trigger-select bits
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_TX,
        ST_TXING,
        ST_WAIT_RX,
        ST_WAIT_DATA,
        ST_RXING
    } itcr_trx_state_t;

    // Transceive control word, bits 9 down to 0
    typedef struct packed {
        logic [5:0] trig;
        logic skip_send;
        logic byte_per_frame_send;
        logic repeated_reception;
        logic initiator;
    } itcr_tctl_t;

    // Events raised outside this block, status bits 19..11 and 10..6, 4, 3
    typedef struct packed {
        logic low_power_detect;
        logic nvm_program_fail;
        logic general_error;
        logic temp_sensor;
        logic subcarrier_det;
        logic sof_det;
        logic [2:0] timer;
        logic active_field_error_flag;
        logic tx_field_on;
        logic tx_field_off;
        logic ext_field_on;
        logic ext_field_off;
        logic card_activated;
        logic mode_detected;
    } itcr_ext_evt_t;

endpackage

// *** hdl/itcr_flag_bank.sv ***
// Sticky status flags, set by hardware events and cleared by write-one pulses.
// Assumes set and clear arrive as single-cycle pulses on the same clock.
`timescale 1ns/1ns
`default_nettype none

module itcr_flag_bank #(
    parameter int W = 20
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clr,
    output logic [W-1:0] o_flags
);

    logic [W-1:0] flag_q;
    logic [W-1:0] flag_d;

    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            // Set wins over a clear in the same cycle; zero clear bits do nothing
            always_comb begin
                flag_d[gi] = i_set[gi] | (flag_q[gi] & ~i_clr[gi]);
            end

            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    flag_q[gi] <= 1'b0;
                end else begin
                    flag_q[gi] <= flag_d[gi];
                end
            end
        end
    endgenerate

    assign o_flags = flag_q;

endmodule

`default_nettype wire

// *** hdl/itcr_regs.sv ***
// Interrupt status, flag clear, transceive control and pin configuration registers,
// with the transceive state sequencer whose state changes feed the flags.
// Assumes a host command decoder drives the register port and a radio datapath
// drives the event and handshake inputs, all synchronous to I_CLK.
`timescale 1ns/1ns
`default_nettype none
`include "itcr_defines.svh"

// Functional notes
// - Flags 0-2: reception end, transmission end, idle
// - Flags 3-5: mode detect, card activation, state change
// - Flags 6-10: field vanish/appear, own field, error
// - Clear bits 20-15 clear upper event flags
// - Clear bits 13-11 timers, 10-0 matching flags
// - Six-bit trigger field; all zero raises nothing
// - Trigger bits order idle through receiving states
// - Skip bit suppresses transmission after wait expiry
// - Hardware clears skip bit entering wait-receive
// - Byte-per-frame: each byte framed, awaits new start
// - Repeated reception re-enables receiver, writes status
// - Frames word aligned, zero padded; pad count computed here
// - Initiator bit changes transceive command behaviour
// - Pin bits 0-6 enable output drivers 1-7
// - Pin bit 7 enables pad slew limiting
// - Transceive: initiator transmits first, else receives first
// - Flag reaches interrupt pin only when enabled
module itcr_regs #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
) (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [ADDR_W-1:0] I_REG_ADDR,
    input wire logic [DATA_W-1:0] I_REG_WDATA,
    output logic [DATA_W-1:0] O_REG_RDATA,
    output logic O_REG_RVALID,
    input wire itcr_pkg::itcr_ext_evt_t I_EVT,
    input wire logic I_CMD_TRANSCEIVE,
    input wire logic I_CMD_STOP,
    input wire logic I_START_SEND,
    input wire logic I_TX_WAIT_DONE,
    input wire logic I_TX_BYTE_DONE,
    input wire logic I_TX_LAST_BYTE,
    input wire logic I_RX_START,
    input wire logic I_RX_BYTE,
    input wire logic I_RX_END,
    output logic O_IRQ,
    output itcr_pkg::itcr_trx_state_t O_TRX_STATE,
    output logic O_TX_ACTIVE,
    output logic O_TX_BYTE_FRAMED,
    output logic O_RX_ENABLE,
    output logic O_RX_STATUS_WR,
    output logic [1:0] O_RX_PAD_CNT,
    output logic [`ITCR_GPO_N-1:0] O_GPO_DRIVE_EN,
    output logic O_SLEW_LIMIT_EN
);

    // Register state
    logic [`ITCR_FLAG_W-1:0] en_q;
    logic [`ITCR_FLAG_W-1:0] en_d;
    itcr_pkg::itcr_tctl_t ctl_q;
    itcr_pkg::itcr_tctl_t ctl_d;
    logic [`ITCR_PIN_W-1:0] pin_q;
    logic [`ITCR_PIN_W-1:0] pin_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic irq_q;
    logic irq_d;
    logic [`ITCR_CLR_W-1:0] clr_pulse;
    logic [`ITCR_FLAG_W-1:0] clr_map;
    logic [`ITCR_FLAG_W-1:0] set_vec;
    logic [`ITCR_FLAG_W-1:0] flags;

    // Sequencer state
    itcr_pkg::itcr_trx_state_t state_q;
    itcr_pkg::itcr_trx_state_t state_d;
    logic pend_q;
    logic pend_d;
    logic [1:0] bcnt_q;
    logic [1:0] bcnt_d;
    logic stwr_q;
    logic stwr_d;
    logic [1:0] pad_q;
    logic [1:0] pad_d;
    logic txact_q;
    logic txact_d;
    logic rxen_q;
    logic rxen_d;
    logic ev_rx_end;
    logic ev_tx_end;
    logic ev_idle;
    logic ev_state;
    logic [5:0] st_onehot;
    logic wr_ctl;

    assign wr_ctl = I_REG_WR && (I_REG_ADDR == `ITCR_OFS_TRX_CTL);

    // Transceive sequencer
    always_comb begin
        state_d = state_q;
        pend_d = pend_q | I_START_SEND;
        bcnt_d = bcnt_q;
        stwr_d = 1'b0;
        pad_d = pad_q;
        ev_rx_end = 1'b0;
        ev_tx_end = 1'b0;
        case (state_q)
            itcr_pkg::ST_IDLE: begin
                if (I_CMD_TRANSCEIVE) begin
                    if (ctl_q.initiator) begin
                        state_d = itcr_pkg::ST_WAIT_TX;
                    end else begin
                        state_d = itcr_pkg::ST_WAIT_RX;
                    end
                end
            end
            itcr_pkg::ST_WAIT_TX: begin
                if (pend_q && I_TX_WAIT_DONE) begin
                    pend_d = 1'b0;
                    if (ctl_q.skip_send) begin
                        state_d = itcr_pkg::ST_WAIT_RX;
                    end else begin
                        state_d = itcr_pkg::ST_TXING;
                    end
                end
            end
            itcr_pkg::ST_TXING: begin
                if (I_TX_BYTE_DONE) begin
                    if (ctl_q.byte_per_frame_send) begin
                        ev_tx_end = 1'b1;
                        if (I_TX_LAST_BYTE) begin
                            state_d = itcr_pkg::ST_WAIT_RX;
                        end else begin
                            state_d = itcr_pkg::ST_WAIT_TX;
                        end
                    end else if (I_TX_LAST_BYTE) begin
                        ev_tx_end = 1'b1;
                        state_d = itcr_pkg::ST_WAIT_RX;
                    end
                end
            end
            itcr_pkg::ST_WAIT_RX: begin
                state_d = itcr_pkg::ST_WAIT_DATA;
            end
            itcr_pkg::ST_WAIT_DATA: begin
                if (I_RX_START) begin
                    state_d = itcr_pkg::ST_RXING;
                end
            end
            itcr_pkg::ST_RXING: begin
                if (I_RX_BYTE) begin
                    bcnt_d = bcnt_q + 2'd1;
                end
                if (I_RX_END) begin
                    ev_rx_end = 1'b1;
                    bcnt_d = 2'd0;
                    if (ctl_q.repeated_reception) begin
                        stwr_d = 1'b1;
                        // Status byte plus data, rounded up to a word with zeros
                        pad_d = 2'd0 - (bcnt_q + 2'(I_RX_BYTE) + 2'd1);
                        state_d = itcr_pkg::ST_WAIT_DATA;
                    end else if (ctl_q.initiator) begin
                        state_d = itcr_pkg::ST_WAIT_TX;
                    end else begin
                        state_d = itcr_pkg::ST_WAIT_TX;
                    end
                end
            end
            default: begin
                state_d = itcr_pkg::ST_IDLE;
            end
        endcase
        if (I_CMD_STOP) begin
            state_d = itcr_pkg::ST_IDLE;
            pend_d = 1'b0;
            bcnt_d = 2'd0;
        end
        txact_d = (state_d == itcr_pkg::ST_TXING);
        rxen_d = (state_d == itcr_pkg::ST_WAIT_DATA) || (state_d == itcr_pkg::ST_RXING);
    end

    // Entry into a state raises state change when its trigger bit is set
    always_comb begin
        st_onehot = 6'h01 << state_d;
        ev_state = (state_d != state_q) && |(st_onehot & ctl_q.trig);
        ev_idle = (state_d == itcr_pkg::ST_IDLE) && (state_q != itcr_pkg::ST_IDLE);
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            state_q <= itcr_pkg::ST_IDLE;
            pend_q <= 1'b0;
            bcnt_q <= 2'd0;
            stwr_q <= 1'b0;
            pad_q <= 2'd0;
            txact_q <= 1'b0;
            rxen_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pend_q <= pend_d;
            bcnt_q <= bcnt_d;
            stwr_q <= stwr_d;
            pad_q <= pad_d;
            txact_q <= txact_d;
            rxen_q <= rxen_d;
        end
    end

    // Set and clear vectors at status positions
    always_comb begin
        set_vec = {I_EVT.low_power_detect, I_EVT.nvm_program_fail, I_EVT.general_error,
                   I_EVT.temp_sensor, I_EVT.subcarrier_det, I_EVT.sof_det, I_EVT.timer,
                   I_EVT.active_field_error_flag, I_EVT.tx_field_on, I_EVT.tx_field_off,
                   I_EVT.ext_field_on, I_EVT.ext_field_off, ev_state, I_EVT.card_activated,
                   I_EVT.mode_detected, ev_idle, ev_tx_end, ev_rx_end};
        clr_map = {clr_pulse[`ITCR_CLR_HI_MSB:`ITCR_CLR_HI_LSB],
                   clr_pulse[`ITCR_CLR_LO_MSB:0]};
    end

    itcr_flag_bank #(
        .W(`ITCR_FLAG_W)
    ) u_flags (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_set(set_vec),
        .i_clr(clr_map),
        .o_flags(flags)
    );

    // Register access
    always_comb begin
        en_d = en_q;
        ctl_d = ctl_q;
        pin_d = pin_q;
        clr_pulse = '0;
        rvalid_d = I_REG_RD;
        rdata_d = `ITCR_RST_DATA;
        if (I_REG_RD) begin
            case (I_REG_ADDR)
                `ITCR_OFS_IRQ_EN: rdata_d = DATA_W'(en_q);
                `ITCR_OFS_IRQ_STATUS: rdata_d = DATA_W'(flags);
                `ITCR_OFS_TRX_CTL: rdata_d = DATA_W'(ctl_q);
                `ITCR_OFS_PIN_CFG: rdata_d = DATA_W'(pin_q);
                default: rdata_d = `ITCR_RST_DATA;
            endcase
        end
        if ((state_d == itcr_pkg::ST_WAIT_RX) && (state_q != itcr_pkg::ST_WAIT_RX)
            && !wr_ctl) begin
            ctl_d.skip_send = 1'b0;
        end
        if (I_REG_WR) begin
            case (I_REG_ADDR)
                `ITCR_OFS_IRQ_EN: en_d = I_REG_WDATA[`ITCR_FLAG_W-1:0];
                `ITCR_OFS_IRQ_CLEAR: clr_pulse = I_REG_WDATA[`ITCR_CLR_W-1:0];
                `ITCR_OFS_TRX_CTL: ctl_d = itcr_pkg::itcr_tctl_t'(I_REG_WDATA[`ITCR_CTL_W-1:0]);
                `ITCR_OFS_PIN_CFG: pin_d = I_REG_WDATA[`ITCR_PIN_W-1:0];
                default: en_d = en_q;
            endcase
        end
        irq_d = |(flags & en_q);
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            en_q <= `ITCR_RST_IRQ_EN;
            ctl_q <= `ITCR_RST_TRX_CTL;
            pin_q <= `ITCR_RST_PIN_CFG;
            rdata_q <= `ITCR_RST_DATA;
            rvalid_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            en_q <= en_d;
            ctl_q <= ctl_d;
            pin_q <= pin_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            irq_q <= irq_d;
        end
    end

    assign O_REG_RDATA = rdata_q;
    assign O_REG_RVALID = rvalid_q;
    assign O_IRQ = irq_q;
    assign O_TRX_STATE = state_q;
    assign O_TX_ACTIVE = txact_q;
    assign O_RX_ENABLE = rxen_q;
    assign O_RX_STATUS_WR = stwr_q;
    assign O_RX_PAD_CNT = pad_q;
    assign O_TX_BYTE_FRAMED = ctl_q.byte_per_frame_send;
    assign O_GPO_DRIVE_EN = pin_q[`ITCR_GPO_N-1:0];
    assign O_SLEW_LIMIT_EN = pin_q[`ITCR_PIN_SLEW];

    // Checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);

    sequence s_clr_rx_flag;
        I_REG_WR && (I_REG_ADDR == `ITCR_OFS_IRQ_CLEAR) && I_REG_WDATA[0] && !ev_rx_end;
    endsequence

    sequence s_skip_ready;
        (state_q == itcr_pkg::ST_WAIT_TX) && pend_q && I_TX_WAIT_DONE && ctl_q.skip_send
            && !I_CMD_STOP;
    endsequence

    a_clear_drops_flag: assert property (s_clr_rx_flag |=> !flags[0])
        else $error("receive-end flag not cleared by write one");
    a_clear_hi_map: assert property (I_REG_WR && (I_REG_ADDR == `ITCR_OFS_IRQ_CLEAR)
        && I_REG_WDATA[20] && !I_EVT.low_power_detect |=> !flags[19])
        else $error("low-power detect flag not cleared by bit 20");
    a_flag_sticks: assert property (flags[1] && !clr_map[1] |=> flags[1])
        else $error("transmit-end flag dropped without clear");
    a_set_beats_clr: assert property (ev_rx_end && clr_map[0] |=> flags[0])
        else $error("event lost against clear");
    a_skip_no_tx: assert property (s_skip_ready |=> state_q == itcr_pkg::ST_WAIT_RX
        ##1 !ctl_q.skip_send)
        else $error("skip send did not bypass transmission");
    a_trig_zero_quiet: assert property (ctl_q.trig == 6'h00 |-> !set_vec[5])
        else $error("state change flagged with empty trigger field");
    a_initiator_first: assert property ((state_q == itcr_pkg::ST_IDLE) && I_CMD_TRANSCEIVE
        && !I_CMD_STOP |=> (state_q == (ctl_q.initiator ? itcr_pkg::ST_WAIT_TX
        : itcr_pkg::ST_WAIT_RX)) || $past(ctl_q.initiator) != ctl_q.initiator)
        else $error("transceive start ignored initiator bit");
    a_rx_repeat: assert property ((state_q == itcr_pkg::ST_RXING) && I_RX_END && !I_CMD_STOP
        && ctl_q.repeated_reception |=> O_RX_STATUS_WR && O_RX_ENABLE)
        else $error("repeated reception did not re-arm receiver");
    a_irq_gate: assert property (##1 O_IRQ == |($past(flags) & $past(en_q)))
        else $error("interrupt pin not gated by enables");
    a_gpo_write: assert property (I_REG_WR && (I_REG_ADDR == `ITCR_OFS_PIN_CFG)
        |=> O_GPO_DRIVE_EN == $past(I_REG_WDATA[6:0])
        && O_SLEW_LIMIT_EN == $past(I_REG_WDATA[7]))
        else $error("pin configuration not applied");

endmodule

`default_nettype wire

// *** testbench/itcr_host_model.sv ***
// Host model: issues register writes and reads on the register port.
// Assumes the design takes a strobe at the rising edge and answers a read one cycle later.
`timescale 1ns/1ns
`default_nettype none

module itcr_host_model (
    input wire logic i_clk,
    input wire logic [31:0] i_rdata,
    input wire logic i_rvalid,
    output var logic o_wr,
    output var logic o_rd,
    output var logic [7:0] o_addr,
    output var logic [31:0] o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'hFF;
        o_wdata = 32'h0000_0000;
    end

    // Write-one clear words go out whole, zero bits leave flags alone
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge i_clk);
        o_wr = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask

    // Read answer is taken only while valid, bounded wait
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int i;
        d = 32'hxxxx_xxxx;
        @(negedge i_clk);
        o_rd = 1'b1;
        o_addr = a;
        @(negedge i_clk);
        o_rd = 1'b0;
        o_addr = ~a;
        for (i = 0; i < 4; i++) begin
            if (i_rvalid === 1'b1) begin
                d = i_rdata;
                break;
            end
            @(posedge i_clk);
            #1;
        end
    endtask
endmodule

`default_nettype wire

// *** testbench/test_irq_and_transceive_control_regs.sv ***
// Testbench of the interrupt and transceive register group.
// Assumes the host model for register access; handshakes driven here at falling edges.
`timescale 1ns/1ns
`default_nettype none

module test_irq_and_transceive_control_regs;
    localparam int TRX = 6, STP = 5, SND = 4, BYT = 3, RXS = 2, RXB = 1, RXE = 0;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wr, rd, rvalid, irq, tx_act, framed, rx_en, st_wr, slew;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [6:0] hs = 7'h00;
    logic tx_wait = 1'b0;
    logic tx_last = 1'b0;
    logic [1:0] pad;
    logic [6:0] gpo;
    itcr_pkg::itcr_ext_evt_t evt = '0;
    itcr_pkg::itcr_trx_state_t st;
    int n_fail = 0;
    int n_compared = 0;

    always #4 clk = ~clk;

    itcr_host_model u_host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr),
        .o_rd(rd), .o_addr(addr), .o_wdata(wdata));

    itcr_regs u_itcr_regs (.I_CLK(clk), .I_SRST(srst), .I_REG_WR(wr), .I_REG_RD(rd),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
        .I_EVT(evt), .I_CMD_TRANSCEIVE(hs[TRX]), .I_CMD_STOP(hs[STP]),
        .I_START_SEND(hs[SND]), .I_TX_WAIT_DONE(tx_wait), .I_TX_BYTE_DONE(hs[BYT]),
        .I_TX_LAST_BYTE(tx_last), .I_RX_START(hs[RXS]), .I_RX_BYTE(hs[RXB]),
        .I_RX_END(hs[RXE]), .O_IRQ(irq), .O_TRX_STATE(st), .O_TX_ACTIVE(tx_act),
        .O_TX_BYTE_FRAMED(framed), .O_RX_ENABLE(rx_en), .O_RX_STATUS_WR(st_wr),
        .O_RX_PAD_CNT(pad), .O_GPO_DRIVE_EN(gpo), .O_SLEW_LIMIT_EN(slew));

    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        u_host.rd(a, v);
        chk(v, e);
        if ($isunknown(v)) complete_run();
    endtask

    task automatic pulse(input int b);
        @(negedge clk);
        hs[b] = 1'b1;
        @(negedge clk);
        hs = 7'h00;
    endtask

    task automatic evp(input itcr_pkg::itcr_ext_evt_t e);
        @(negedge clk);
        evt = e;
        @(negedge clk);
        evt = '0;
    endtask

    task automatic wst(input itcr_pkg::itcr_trx_state_t s);
        int i;
        for (i = 0; i < 10; i++) begin
            if (st === s) break;
            @(posedge clk);
            #1;
        end
        chk(32'(st), 32'(s));
        if (st !== s) complete_run();
    endtask

    task automatic t_reset;
        rdc(8'h04, 32'h0000_0000);
        rdc(8'h05, 32'h0000_0000);
        rdc(8'h01, 32'h0000_0000);
        rdc(8'h02, 32'h0000_0000);
        chk(32'({gpo, slew, irq}), 32'h0000_0000);
    endtask

    task automatic t_pins;
        u_host.wr(8'h05, 32'h0000_00A5);
        rdc(8'h05, 32'h0000_00A5);
        chk(32'({gpo, slew}), {24'h0, 7'h25, 1'b1});
        u_host.wr(8'h05, 32'hFFFF_FF5A);
        chk(32'({gpo, slew}), {24'h0, 7'h5A, 1'b0});
        u_host.wr(8'h09, 32'hFFFF_FFFF);
        rdc(8'h09, 32'h0000_0000);
        rdc(8'h03, 32'h0000_0000);
    endtask

    task automatic t_flags;
        evp(16'hFFFF);
        repeat (5) @(negedge clk);
        rdc(8'h02, 32'h000F_FFD8);
        u_host.wr(8'h03, 32'h0000_4000);
        u_host.wr(8'h03, 32'h0000_0000);
        rdc(8'h02, 32'h000F_FFD8);
        u_host.wr(8'h03, 32'h001F_8000);
        rdc(8'h02, 32'h0000_3FD8);
        u_host.wr(8'h03, 32'h0000_3FFF);
        rdc(8'h02, 32'h0000_0000);
    endtask

    task automatic t_irq;
        u_host.wr(8'h01, 32'h0000_0040);
        rdc(8'h01, 32'h0000_0040);
        evp(16'h0020);
        repeat (3) @(negedge clk);
        chk(32'(irq), 32'h0000_0000);
        evp(16'h0004);
        repeat (3) @(negedge clk);
        chk(32'(irq), 32'h0000_0001);
        u_host.wr(8'h03, 32'h0000_0240);
        repeat (3) @(negedge clk);
        chk(32'(irq), 32'h0000_0000);
    endtask

    task automatic t_initiator;
        u_host.wr(8'h04, 32'h0000_0201);
        pulse(TRX);
        wst(itcr_pkg::ST_WAIT_TX);
        rdc(8'h02, 32'h0000_0000);
        tx_wait = 1'b1;
        tx_last = 1'b1;
        pulse(SND);
        wst(itcr_pkg::ST_TXING);
        chk(32'(tx_act), 32'h0000_0001);
        tx_wait = 1'b0;
        pulse(BYT);
        wst(itcr_pkg::ST_WAIT_DATA);
        chk(32'(rx_en), 32'h0000_0001);
        pulse(RXS);
        wst(itcr_pkg::ST_RXING);
        pulse(RXE);
        wst(itcr_pkg::ST_WAIT_TX);
        rdc(8'h02, 32'h0000_0023);
        pulse(STP);
        wst(itcr_pkg::ST_IDLE);
        rdc(8'h02, 32'h0000_0027);
        u_host.wr(8'h03, 32'h0000_07FF);
    endtask

    task automatic t_skip;
        u_host.wr(8'h04, 32'h0000_0009);
        pulse(TRX);
        wst(itcr_pkg::ST_WAIT_TX);
        tx_wait = 1'b1;
        pulse(SND);
        wst(itcr_pkg::ST_WAIT_DATA);
        tx_wait = 1'b0;
        rdc(8'h02, 32'h0000_0000);
        rdc(8'h04, 32'h0000_0001);
        pulse(STP);
        wst(itcr_pkg::ST_IDLE);
        u_host.wr(8'h03, 32'h0000_07FF);
    endtask

    task automatic t_frame;
        u_host.wr(8'h04, 32'h0000_0005);
        pulse(TRX);
        wst(itcr_pkg::ST_WAIT_TX);
        tx_wait = 1'b1;
        tx_last = 1'b0;
        pulse(SND);
        wst(itcr_pkg::ST_TXING);
        pulse(BYT);
        wst(itcr_pkg::ST_WAIT_TX);
        repeat (3) @(negedge clk);
        chk(32'(st), 32'(itcr_pkg::ST_WAIT_TX));
        rdc(8'h02, 32'h0000_0002);
        tx_last = 1'b1;
        pulse(SND);
        wst(itcr_pkg::ST_TXING);
        pulse(BYT);
        wst(itcr_pkg::ST_WAIT_DATA);
        tx_wait = 1'b0;
        pulse(STP);
        wst(itcr_pkg::ST_IDLE);
        u_host.wr(8'h03, 32'h0000_07FF);
    endtask

    task automatic t_repeat;
        int n;
        int i;
        u_host.wr(8'h04, 32'h0000_0006);
        chk(32'(framed), 32'h0000_0001);
        pulse(TRX);
        wst(itcr_pkg::ST_WAIT_DATA);
        chk(32'(rx_en), 32'h0000_0001);
        for (n = 1; n <= 4; n++) begin
            pulse(RXS);
            repeat (n) pulse(RXB);
            pulse(RXE);
            for (i = 0; i < 4; i++) begin
                if (st_wr === 1'b1) break;
                @(posedge clk);
                #1;
            end
            chk(32'({st_wr, pad}), 32'({1'b1, 2'((4 - ((n + 1) % 4)) % 4)}));
            if (st_wr !== 1'b1) complete_run();
            wst(itcr_pkg::ST_WAIT_DATA);
        end
        pulse(STP);
        wst(itcr_pkg::ST_IDLE);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial begin
        repeat (4) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_pins();
        t_flags();
        t_irq();
        t_initiator();
        t_skip();
        t_frame();
        t_repeat();
        complete_run();
    end
endmodule

`default_nettype wire
